// ==== common/amsc_defines.svh ====
`ifndef AMSC_DEFINES_SVH
`define AMSC_DEFINES_SVH
`define AMSC_SEL_BIT 15
`define AMSC_SCAN_F 14:11
`define AMSC_CHAN_F 10:7
`define AMSC_RST_F 6:5
`define AMSC_PM_F 4:3
`define AMSC_TAG_BIT 2
`define AMSC_SOFTWARE_CONVERT_TRIGGER_BIT 1
`define AMSC_SCAN_NULL 4'h0
`define AMSC_SCAN_MANUAL 4'h1
`define AMSC_SCAN_REPEAT 4'h2
`define AMSC_SCAN_STDINT 4'h3
`define AMSC_SCAN_RESET 4'h1
`define AMSC_CHAN_RESET 4'h0
`define AMSC_PM_RESET 2'h0
`define AMSC_PM_NORMAL 2'h0
`define AMSC_RST_FIFO 2'h1
`define AMSC_RST_ALL 2'h2
`define AMSC_FRAME_LAST 5'h0F
`define AMSC_FRAME_END 5'h10
`define AMSC_MUX_EDGE 5'h0C
`define AMSC_SYNC_RESET 4'h2
`define AMSC_REPEAT_LOW 2'h3
`endif

// ==== common/amsc_pkg.sv ====
package amsc_pkg;
  typedef enum logic [1:0] {SCAN_IDLE, SCAN_CONVERT, SCAN_WAIT} amsc_state_t;
endpackage

// ==== rtl/amsc_sync.sv ====
module amsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= RESET_VALUE;
      syncOut <= RESET_VALUE;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule // amsc_sync

// ==== rtl/amsc_mode_scan_control.sv ====
`include "amsc_defines.svh"

module amsc_mode_scan_control #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic chipSelectN,
  input wire logic serialDataIn,
  output logic serialDataOut,
  input wire logic conversionStartPin,
  input wire logic [11:0] resultData,
  input wire logic resultValid,
  input wire logic [1:0] repeatCountSelect,
  input wire logic averageEnable,
  output logic [3:0] muxSelect,
  output logic convertStart,
  output logic [1:0] powerStateSelect,
  output logic channelTagActive,
  output logic averagingActive,
  output logic internalClockMode,
  output logic fifoClear,
  output logic [$clog2(FIFO_DEPTH):0] fifoCount
);
  localparam int PW = $clog2(FIFO_DEPTH);

  // Link side: everything here but outWord, which the core loads on clk, runs on the serial clock, which only moves inside frames.
  logic [4:0] bitCount;
  logic [4:0] fallCount;
  logic [15:0] shiftIn;
  logic [15:0] rxWord;
  logic rxToggle;
  logic advToggle;
  logic [15:0] outWord;

  always_ff @(posedge serialClock or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitCount <= 5'h00;
      shiftIn <= 16'h0000;
    end else begin
      if (bitCount != `AMSC_FRAME_END) begin
        bitCount <= bitCount + 5'h01;
      end
      shiftIn <= {shiftIn[14:0], serialDataIn};
    end
  end

  // The captured word stays put until the next frame's last bit, long after the core reads it.
  always_ff @(posedge serialClock or posedge reset) begin
    if (reset) begin
      rxWord <= 16'h0000;
      rxToggle <= 1'b0;
    end else if (bitCount == `AMSC_FRAME_LAST) begin
      rxWord <= {shiftIn[14:0], serialDataIn};
      rxToggle <= ~rxToggle;
    end
  end

  always_ff @(negedge serialClock or posedge chipSelectN) begin
    if (chipSelectN) begin
      fallCount <= 5'h00;
    end else if (fallCount != `AMSC_FRAME_END) begin
      fallCount <= fallCount + 5'h01;
    end
  end

  always_ff @(negedge serialClock or posedge reset) begin
    if (reset) begin
      advToggle <= 1'b0;
    end else if (fallCount == `AMSC_MUX_EDGE) begin
      advToggle <= ~advToggle;
    end
  end

  // The output word changes only after a frame's last bit has been clocked in, so it is quiet while being shifted.
  assign serialDataOut = outWord[~fallCount[3:0]];

  a_mux_edge_count: assert property (@(negedge serialClock) disable iff (chipSelectN || reset)
    $changed(advToggle) |-> $past(fallCount) == `AMSC_MUX_EDGE)
    else $error("Multiplexer advance off the thirteenth falling edge.");

  // Core side.
  logic [3:0] syncd;
  logic [3:0] prev;

  amsc_sync #(
    .WIDTH(4),
    .RESET_VALUE(`AMSC_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .asyncIn({rxToggle, advToggle, chipSelectN, conversionStartPin}),
    .syncOut(syncd)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      prev <= `AMSC_SYNC_RESET;
    end else begin
      prev <= syncd;
    end
  end

  function automatic logic [15:0] fmtResult(input logic tagOn, input logic [3:0] chan,
                                            input logic [11:0] data);
    fmtResult = tagOn ? {chan, data} : {data, 4'h0};
  endfunction

  logic [3:0] scanMode;
  logic [3:0] chanSel;
  logic [1:0] powerState;
  logic tagEnable;
  logic swcnvPending;
  amsc_pkg::amsc_state_t state;
  logic [3:0] scanPtr;
  logic [3:0] convCount;
  logic jobManual;
  logic [15:0] fifoMem [FIFO_DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;

  wire frameEvt = syncd[3] ^ prev[3];
  wire advEvt = syncd[2] ^ prev[2];
  wire csRise = syncd[1] & ~prev[1];
  wire pinRise = syncd[0] & ~prev[0];
  wire regWrite = frameEvt & ~rxWord[`AMSC_SEL_BIT];
  wire [3:0] wordScan = rxWord[`AMSC_SCAN_F];
  wire [1:0] wordReset = rxWord[`AMSC_RST_F];
  wire isNull = wordScan == `AMSC_SCAN_NULL;
  wire softReset = regWrite & (wordReset == `AMSC_RST_ALL);
  wire clearReq = regWrite & ((wordReset == `AMSC_RST_FIFO) | softReset);
  wire [3:0] nextScanMode = isNull ? scanMode : wordScan;
  wire [3:0] nextChan = isNull ? chanSel : rxWord[`AMSC_CHAN_F];
  wire manualMode = scanMode == `AMSC_SCAN_MANUAL;
  wire repeatMode = scanMode == `AMSC_SCAN_REPEAT;
  wire stdMode = scanMode == `AMSC_SCAN_STDINT;
  wire internalMode = repeatMode | stdMode;
  wire isIdle = state == amsc_pkg::SCAN_IDLE;
  wire swcnvTaken = isIdle & internalMode & csRise & swcnvPending;
  wire startInt = isIdle & internalMode & (pinRise | (csRise & swcnvPending));
  wire manualKick = isIdle & regWrite & ~softReset & (nextScanMode == `AMSC_SCAN_MANUAL);
  wire lastConv = repeatMode ? convCount == {repeatCountSelect, `AMSC_REPEAT_LOW}
                             : scanPtr == chanSel;
  wire convDone = (state == amsc_pkg::SCAN_WAIT) & resultValid;
  wire fifoFull = fifoCount == FIFO_DEPTH[PW:0];
  wire push = convDone & ~jobManual & ~fifoFull;
  wire pop = frameEvt & internalMode & (fifoCount != '0);
  wire tagOn = tagEnable | internalMode;
  wire [15:0] resultWord = fmtResult(tagOn, scanPtr, resultData);

  // Bit 0 is never looked at; the tag bit is left alone under the null code.
  always_ff @(posedge clk) begin
    if (reset || softReset) begin
      scanMode <= `AMSC_SCAN_RESET;
      chanSel <= `AMSC_CHAN_RESET;
      powerState <= `AMSC_PM_RESET;
      tagEnable <= 1'b0;
    end else if (regWrite) begin
      powerState <= rxWord[`AMSC_PM_F];
      if (!isNull) begin
        scanMode <= wordScan;
        chanSel <= rxWord[`AMSC_CHAN_F];
        tagEnable <= rxWord[`AMSC_TAG_BIT];
      end
    end
  end

  // A fresh write wins over the consumption in the same cycle.
  always_ff @(posedge clk) begin
    if (reset || softReset) begin
      swcnvPending <= 1'b0;
    end else if (regWrite) begin
      swcnvPending <= rxWord[`AMSC_SOFTWARE_CONVERT_TRIGGER_BIT];
    end else if (swcnvTaken) begin
      swcnvPending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      powerStateSelect <= `AMSC_PM_NORMAL;
      channelTagActive <= 1'b0;
      averagingActive <= 1'b0;
      internalClockMode <= 1'b0;
      fifoClear <= 1'b0;
    end else begin
      powerStateSelect <= internalMode ? `AMSC_PM_NORMAL : powerState;
      channelTagActive <= tagOn;
      averagingActive <= internalMode & averageEnable;
      internalClockMode <= internalMode;
      fifoClear <= clearReq;
    end
  end

  always_ff @(posedge clk) begin
    convertStart <= 1'b0;
    if (reset || softReset) begin
      state <= amsc_pkg::SCAN_IDLE;
      scanPtr <= `AMSC_CHAN_RESET;
      convCount <= 4'h0;
      jobManual <= 1'b0;
    end else begin
      case (state)
        amsc_pkg::SCAN_IDLE: begin
          if (manualKick) begin
            scanPtr <= nextChan;
            jobManual <= 1'b1;
            convertStart <= 1'b1;
            state <= amsc_pkg::SCAN_WAIT;
          end else if (startInt) begin
            scanPtr <= repeatMode ? chanSel : 4'h0;
            convCount <= 4'h0;
            jobManual <= 1'b0;
            state <= amsc_pkg::SCAN_CONVERT;
          end else if (advEvt && internalMode) begin
            if (repeatMode) begin
              scanPtr <= chanSel;
            end else begin
              scanPtr <= (scanPtr == chanSel) ? 4'h0 : scanPtr + 4'h1;
            end
          end
        end
        amsc_pkg::SCAN_CONVERT: begin
          convertStart <= 1'b1;
          state <= amsc_pkg::SCAN_WAIT;
        end
        amsc_pkg::SCAN_WAIT: begin
          if (resultValid) begin
            if (jobManual || lastConv) begin
              state <= amsc_pkg::SCAN_IDLE;
            end else begin
              scanPtr <= stdMode ? scanPtr + 4'h1 : scanPtr;
              convCount <= convCount + 4'h1;
              state <= amsc_pkg::SCAN_CONVERT;
            end
          end
        end
        default: state <= amsc_pkg::SCAN_IDLE;
      endcase
    end
  end

  assign muxSelect = scanPtr;

  // A full FIFO drops further results rather than stalling the converter.
  always_ff @(posedge clk) begin
    if (reset || clearReq) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fifoCount <= '0;
      outWord <= 16'h0000;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifoMem[i] <= 16'h0000;
      end
    end else begin
      if (push) begin
        fifoMem[wrPtr] <= resultWord;
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      fifoCount <= fifoCount + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      if (convDone && jobManual) begin
        outWord <= resultWord;
      end else if (pop) begin
        outWord <= fifoMem[rdPtr];
      end
    end
  end

  a_null_keeps_scan: assert property (@(posedge clk) disable iff (reset)
    regWrite && isNull && !softReset |=> scanMode == $past(scanMode) && chanSel == $past(chanSel))
    else $error("Null scan code changed the scan mode.");

  a_null_takes_power: assert property (@(posedge clk) disable iff (reset)
    regWrite && isNull && !softReset |=> powerState == $past(rxWord[`AMSC_PM_F])
      && swcnvPending == $past(rxWord[`AMSC_SOFTWARE_CONVERT_TRIGGER_BIT]))
    else $error("Null scan code blocked a power or convert update.");

  a_manual_convert: assert property (@(posedge clk) disable iff (reset)
    manualKick |=> convertStart && muxSelect == $past(nextChan) ##1 !convertStart)
    else $error("Manual frame did not start exactly one conversion.");

  a_manual_result: assert property (@(posedge clk) disable iff (reset)
    convDone && jobManual && tagEnable |=> outWord == {$past(scanPtr), $past(resultData)})
    else $error("Tagged manual result word is wrong.");

  a_internal_tag: assert property (@(posedge clk) disable iff (reset)
    push && internalMode |-> resultWord[15:12] == scanPtr)
    else $error("Internal clock result lacks the channel address.");

  a_software_convert_trigger_start: assert property (@(posedge clk) disable iff (reset)
    swcnvTaken && !softReset |=> state == amsc_pkg::SCAN_CONVERT ##1 convertStart)
    else $error("Software convert did not start on chip-select rise.");

  a_std_ascend: assert property (@(posedge clk) disable iff (reset)
    stdMode && !isIdle && resultValid && !lastConv && !softReset
      |=> scanPtr == $past(scanPtr) + 4'h1)
    else $error("Standard scan did not step to the next channel.");

  a_repeat_hold: assert property (@(posedge clk) disable iff (reset)
    repeatMode && !isIdle && !softReset |=> scanPtr == chanSel)
    else $error("Repeat scan left channel N.");

  a_fifo_clear: assert property (@(posedge clk) disable iff (reset)
    clearReq |=> fifoCount == '0 && outWord == 16'h0000 && fifoClear)
    else $error("FIFO reset code did not empty the FIFO.");

  a_no_manual_avg: assert property (@(posedge clk) disable iff (reset)
    manualMode |=> !averagingActive)
    else $error("Averaging shown active in manual mode.");
endmodule // amsc_mode_scan_control

// ==== dv/amsc_host_model.sv ====
module amsc_host_model (
  output logic serialClock,
  output logic chipSelectN,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // Chip select rises after time zero, so the link counters see a clearing edge for certain.
  initial begin
    serialClock = 1'b0;
    chipSelectN = 1'b0;
    serialDataIn = 1'b0;
    #1 chipSelectN = 1'b1;
  end

  // The serial clock only runs inside a frame, like a real host.
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    chipSelectN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialDataIn = w[i];
      #7.5 serialClock = 1'b1;
      r[i] = serialDataOut;
      #7.5 serialClock = 1'b0;
    end
    #7.5 chipSelectN = 1'b1;
    // The released data line has no pull, so it must not keep showing the last bit.
    serialDataIn = ~serialDataIn;
    #40;
  endtask
endmodule // amsc_host_model

// ==== dv/adc_mode_scan_control_tb.sv ====
module adc_mode_scan_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, serialClock, chipSelectN, serialDataIn, serialDataOut;
  logic conversionStartPin, resultValid, averageEnable, convertStart;
  logic channelTagActive, averagingActive, internalClockMode, fifoClear;
  logic [11:0] resultData;
  logic [1:0] repeatCountSelect, powerStateSelect;
  logic [3:0] muxSelect, ch;
  logic [4:0] fifoCount;
  logic [3:0] chanQ[$];
  logic [15:0] outQ[$];
  logic [15:0] rx;
  logic tagOn = 1'b0;
  logic intMode = 1'b0;
  int err_total = 0, checked = 0, cycles = 0, clears = 0;

  amsc_mode_scan_control #(.FIFO_DEPTH(16)) amsc_mode_scan_control_i (
    .clk(clk), .reset(reset), .serialClock(serialClock), .chipSelectN(chipSelectN),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .conversionStartPin(conversionStartPin), .resultData(resultData),
    .resultValid(resultValid), .repeatCountSelect(repeatCountSelect),
    .averageEnable(averageEnable), .muxSelect(muxSelect), .convertStart(convertStart),
    .powerStateSelect(powerStateSelect), .channelTagActive(channelTagActive),
    .averagingActive(averagingActive), .internalClockMode(internalClockMode),
    .fifoClear(fifoClear), .fifoCount(fifoCount));
  amsc_host_model amsc_host_model_i (.serialClock(serialClock), .chipSelectN(chipSelectN),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (fifoClear === 1'b1) clears <= clears + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // Converter stand-in: every start is matched against the oldest expected channel.
  always @(posedge clk) begin
    if (convertStart === 1'b1) begin
      ch = (chanQ.size() == 0) ? 4'hX : chanQ.pop_front();
      chk({12'h000, ch}, {12'h000, muxSelect});
      repeat (3) @(posedge clk);
      #1 resultData = 12'($urandom);
      resultValid = 1'b1;
      outQ.push_back((tagOn | intMode) ? {ch, resultData} : {resultData, 4'h0});
      @(posedge clk);
      #1 resultValid = 1'b0;
    end
  end

  function automatic logic [15:0] mw(input logic [3:0] sc, input logic [3:0] cs,
      input logic [1:0] rs, input logic [1:0] pm, input logic tg, input logic sw);
    return {1'b0, sc, cs, rs, pm, tg, sw, 1'($urandom)};
  endfunction

  task automatic send(input logic [15:0] w);
    amsc_host_model_i.xfer(w, rx);
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic drain();
    for (int i = 0; i < 600 && chanQ.size() != 0; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic pulse_start();
    conversionStartPin = 1'b1;
    repeat (6) @(posedge clk);
    #1 conversionStartPin = 1'b0;
    drain();
  endtask

  initial begin
    // Reset rises after time zero so that the link flops with an asynchronous reset catch it.
    reset = 1'b0;
    conversionStartPin = 1'b0;
    resultData = 12'h000;
    resultValid = 1'b0;
    repeatCountSelect = 2'h0;
    void'($urandom(32'hC8CF));
    averageEnable = 1'($urandom);
    #1 reset = 1'b1;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(16'h0000, {8'h00, muxSelect, powerStateSelect, channelTagActive, internalClockMode});
    $display("test reset done");
    tagOn = 1'b1;
    chanQ.push_back(4'h5);
    send(mw(4'h1, 4'h5, 2'h0, 2'h1, 1'b1, 1'b0));
    chk(16'h000C, {11'h000, powerStateSelect, channelTagActive, internalClockMode, averagingActive});
    tagOn = 1'b0;
    chanQ.push_back(4'h3);
    send(mw(4'h1, 4'h3, 2'h0, 2'h0, 1'b0, 1'b0));
    chk(outQ.pop_front(), rx);
    intMode = 1'b1;
    send(mw(4'h3, 4'h3, 2'h0, 2'h2, 1'b0, 1'b0));
    chk(outQ.pop_front(), rx);
    chk({11'h000, 2'h0, 1'b1, 1'b1, averageEnable}, {11'h000, powerStateSelect, channelTagActive, internalClockMode, averagingActive});
    $display("test manual done");
    for (int c = 0; c < 4; c++) chanQ.push_back(4'(c));
    pulse_start();
    chk(16'h0004, 16'(fifoCount));
    send(16'h8000);
    for (int c = 0; c < 4; c++) begin
      send(16'h8000);
      chk(outQ.pop_front(), rx);
    end
    $display("test standard scan done");
    repeatCountSelect = 2'($urandom);
    averageEnable = ~averageEnable;
    send(mw(4'h2, 4'h7, 2'h0, 2'h0, 1'b0, 1'b0));
    for (int c = 0; c < 4 * (repeatCountSelect + 1); c++) chanQ.push_back(4'h7);
    pulse_start();
    chk(16'(4 * (repeatCountSelect + 1)), 16'(fifoCount));
    chk({15'h0000, averageEnable}, {15'h0000, averagingActive});
    send(mw(4'h0, 4'h9, 2'h1, 2'h0, 1'b0, 1'b0));
    outQ.delete();
    chk(16'h0001, 16'(clears));
    chk(16'h0000, 16'(fifoCount));
    chk(16'h0001, {15'h0000, internalClockMode});
    $display("test repeat and clear done");
    send(mw(4'h3, 4'h1, 2'h0, 2'h0, 1'b0, 1'b0));
    chanQ.push_back(4'h0);
    chanQ.push_back(4'h1);
    send(mw(4'h0, 4'hF, 2'h0, 2'h0, 1'b0, 1'b1));
    send(16'h8000);
    drain();
    send(16'h8000);
    chk(outQ.pop_front(), rx);
    send(16'h8000);
    chk(outQ.pop_front(), rx);
    drain();
    chk(16'h0000, 16'(chanQ.size()));
    $display("test software convert done");
    send(mw(4'h3, 4'h2, 2'h2, 2'h3, 1'b1, 1'b1));
    chk(16'h0002, 16'(clears));
    chk(16'h0000, {8'h00, muxSelect, powerStateSelect, channelTagActive, internalClockMode});
    chk(16'h0000, 16'(fifoCount));
    $display("test soft reset done");
    end_of_test();
  end
endmodule // adc_mode_scan_control_tb
